// ===== rtl/prm_master.v
// Functional notes
// R1: Master enable off suppresses every alarm, trip and trip command.
// R2: Master block permit plus either block input blocks whole protection.
// R3: Master hard trip-command block suppresses all trip commands.
// R4: Master trip-command permit plus its input suppresses all commands.
// R5: Supervision-only elements keep local states, no general or command.
// R6: Element alarm asserts while its fault criterion is detected.
// R7: Element trip asserts if fault persists after its delay elapses.
// R8: General alarm is OR of non-supervision element alarms.
// R9: General trip is OR of non-supervision element trips.
// R10: Trip command needs trip and no element or master command block.
// R11: Per-phase alarm and trip collectors OR non-supervision phase signals.
// R12: Only single-phase capable elements drive phase collectors.
// R13: Each element has its own enable; disabled means no outputs.
// R14: Element with block permit is blocked exactly while its input is.
// R15: Element hard trip-command block suppresses its trip command.
// R16: Element command permit plus selected input suppresses its command.
// R17: Block inputs are selectable from any internal or external signal; the pool holds only element alarms, element trips and ext_sig_i.
// R18: Phase current elements also blockable by reverse interlocking.
// R19: Fault drop restarts timer; blocking clears timer, alarm and trip.
// R20: Trip manager treats commands as levels, opens breaker while asserted.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "prm_regs.vh"
module prm_master #(
  parameter N = 4,
  parameter EXT_W = 8,
  parameter SW = 5,
  parameter TW = 16
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [7:0] addr_i,
  input wire [31:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rd_data_o,
  input wire [N-1:0] fault_i,
  input wire [3*N-1:0] fault_ph_i,
  input wire [N-1:0] rev_interlock_i,
  input wire [EXT_W-1:0] ext_sig_i,
  output wire [N-1:0] elem_alarm_o,
  output wire [N-1:0] elem_trip_o,
  output reg gen_alarm_o,
  output reg gen_trip_o,
  output reg [2:0] general_phase_alarm_o,
  output reg [2:0] general_phase_trip_o,
  output reg [N-1:0] trip_command_o,
  output reg prot_blocked_o
);
  localparam PW = EXT_W + 2 * N;
  // Index width for the element register arrays
  localparam IW = (N > 1) ? $clog2(N) : 1;

  reg [31:0] global_q;
  reg [31:0] elem_ctrl_q [0:N-1];
  reg [TW-1:0] elem_delay_q [0:N-1];
  reg tc_blocked_q;
  reg [31:0] rd_mux;

  wire [PW-1:0] pool;
  wire sel_a_hit;
  wire sel_b_hit;
  wire sel_tc_hit;
  wire prot_block;
  wire master_tc_block;
  wire [N-1:0] elem_blk_hit;
  wire [N-1:0] elem_tc_hit;
  wire [N-1:0] elem_active;
  wire [N-1:0] superv;
  wire [N-1:0] single_ph;
  wire [N-1:0] cmd_d;
  wire [3*N-1:0] alarm_ph;
  wire [3*N-1:0] trip_ph;
  wire in_elem;
  wire [7:0] elem_ofs;
  wire [7:0] elem_idx;

  // R17 signal pool
  assign pool = {elem_trip_o, elem_alarm_o, ext_sig_i};

  prm_sel #(
    .PW(PW),
    .SW(SW)
  ) u_sel_a (
    .pool_i(pool),
    .idx_i(global_q[`PRM_G_SEL_A_LSB +: SW]),
    .hit_o(sel_a_hit)
  );

  prm_sel #(
    .PW(PW),
    .SW(SW)
  ) u_sel_b (
    .pool_i(pool),
    .idx_i(global_q[`PRM_G_SEL_B_LSB +: SW]),
    .hit_o(sel_b_hit)
  );

  prm_sel #(
    .PW(PW),
    .SW(SW)
  ) u_sel_tc (
    .pool_i(pool),
    .idx_i(global_q[`PRM_G_SEL_TC_LSB +: SW]),
    .hit_o(sel_tc_hit)
  );

  // R1 master enable
  // R2 master temporary block
  assign prot_block = !global_q[`PRM_G_ENABLE] ||
    (global_q[`PRM_G_BLK_PERMIT] && (sel_a_hit || sel_b_hit));

  // R3 master hard block
  // R4 master signal block
  assign master_tc_block = global_q[`PRM_G_TC_HARD] ||
    (global_q[`PRM_G_TC_PERMIT] && sel_tc_hit);

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_elem
      wire [31:0] ctrl;

      assign ctrl = elem_ctrl_q[g];
      assign superv[g] = ctrl[`PRM_E_SUPERV];
      assign single_ph[g] = ctrl[`PRM_E_SINGLE_PH];

      prm_sel #(
        .PW(PW),
        .SW(SW)
      ) u_sel_blk (
        .pool_i(pool),
        .idx_i(ctrl[`PRM_E_SEL_BLK_LSB +: SW]),
        .hit_o(elem_blk_hit[g])
      );

      prm_sel #(
        .PW(PW),
        .SW(SW)
      ) u_sel_tc (
        .pool_i(pool),
        .idx_i(ctrl[`PRM_E_SEL_TC_LSB +: SW]),
        .hit_o(elem_tc_hit[g])
      );

      // R13 element enable
      // R14 element signal block
      // R18 reverse interlock
      assign elem_active[g] = !prot_block && ctrl[`PRM_E_ENABLE] &&
        !(ctrl[`PRM_E_BLK_PERMIT] && elem_blk_hit[g]) &&
        !(ctrl[`PRM_E_REV_IL] && rev_interlock_i[g]);

      prm_elem #(
        .TW(TW)
      ) u_elem (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .active_i(elem_active[g]),
        .fault_i(fault_i[g]),
        .fault_ph_i(fault_ph_i[3*g +: 3]),
        .delay_i(elem_delay_q[g]),
        .alarm_o(elem_alarm_o[g]),
        .trip_o(elem_trip_o[g]),
        .alarm_ph_o(alarm_ph[3*g +: 3]),
        .trip_ph_o(trip_ph[3*g +: 3])
      );

      // R5 no command when supervising
      // R10 command gating
      // R15 element hard block
      // R16 element signal block
      assign cmd_d[g] = elem_trip_o[g] && elem_active[g] && !superv[g] &&
        !ctrl[`PRM_E_TC_HARD] &&
        !(ctrl[`PRM_E_TC_PERMIT] && elem_tc_hit[g]) &&
        !master_tc_block;

      // Per-element control and delay registers
      always @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          elem_ctrl_q[g] <= `PRM_ELEM_RST;
          elem_delay_q[g] <= `PRM_DELAY_RST;
        end
        else if (wr_i && in_elem && elem_idx == g)
        begin
          if (elem_ofs[2])
          begin
            elem_delay_q[g] <= wr_data_i[TW-1:0];
          end
          else
          begin
            elem_ctrl_q[g] <= wr_data_i;
          end
        end
      end
    end
  endgenerate


  // Eight bytes per element window
  assign elem_ofs = addr_i - `PRM_ELEM_BASE;
  assign elem_idx = {3'h0, elem_ofs[7:3]};
  assign in_elem = (addr_i >= `PRM_ELEM_BASE) && (elem_idx < N) &&
    (addr_i[1:0] == 2'h0);

  // Collectors, registered
  reg ga_d;
  reg gt_d;
  reg [2:0] pa_d;
  reg [2:0] pt_d;
  integer i;

  always @*
  begin
    ga_d = 1'b0;
    gt_d = 1'b0;
    pa_d = 3'h0;
    pt_d = 3'h0;
    for (i = 0; i < N; i = i + 1)
    begin
      // R5 supervision excluded
      if (!superv[i])
      begin
        // R8 general alarm
        ga_d = ga_d | elem_alarm_o[i];
        // R9 general trip
        gt_d = gt_d | elem_trip_o[i];
        // R11 phase collectors
        // R12 single-phase only
        if (single_ph[i])
        begin
          pa_d = pa_d | alarm_ph[3*i +: 3];
          pt_d = pt_d | trip_ph[3*i +: 3];
        end
      end
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gen_alarm_o <= 1'b0;
      gen_trip_o <= 1'b0;
      general_phase_alarm_o <= 3'h0;
      general_phase_trip_o <= 3'h0;
      trip_command_o <= {N{1'b0}};
      prot_blocked_o <= 1'b1;
      tc_blocked_q <= 1'b0;
    end
    // R1 everything off
    else if (prot_block)
    begin
      gen_alarm_o <= 1'b0;
      gen_trip_o <= 1'b0;
      general_phase_alarm_o <= 3'h0;
      general_phase_trip_o <= 3'h0;
      trip_command_o <= {N{1'b0}};
      prot_blocked_o <= 1'b1;
      tc_blocked_q <= master_tc_block;
    end
    else
    begin
      gen_alarm_o <= ga_d;
      gen_trip_o <= gt_d;
      general_phase_alarm_o <= pa_d;
      general_phase_trip_o <= pt_d;
      trip_command_o <= cmd_d;
      prot_blocked_o <= 1'b0;
      tc_blocked_q <= master_tc_block;
    end
  end

  // Global control register
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      global_q <= `PRM_GLOBAL_RST;
    end
    else if (wr_i && addr_i == `PRM_GLOBAL_CTRL)
    begin
      global_q <= wr_data_i;
    end
  end

  // Read mux
  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (addr_i == `PRM_GLOBAL_CTRL)
    begin
      rd_mux = global_q;
    end
    else if (addr_i == `PRM_STATUS)
    begin
      rd_mux[`PRM_S_GEN_ALARM] = gen_alarm_o;
      rd_mux[`PRM_S_GEN_TRIP] = gen_trip_o;
      rd_mux[`PRM_S_PH_ALARM_LSB +: 3] = general_phase_alarm_o;
      rd_mux[`PRM_S_PH_TRIP_LSB +: 3] = general_phase_trip_o;
      rd_mux[`PRM_S_PROT_BLK] = prot_blocked_o;
      rd_mux[`PRM_S_TC_BLK] = tc_blocked_q;
    end
    else if (addr_i == `PRM_ELEM_STATUS)
    begin
      rd_mux[N-1:0] = elem_alarm_o;
      rd_mux[`PRM_S_TRIP_LSB +: N] = elem_trip_o;
    end
    else if (addr_i == `PRM_TRIP_STATUS)
    begin
      rd_mux[N-1:0] = trip_command_o;
    end
    else if (in_elem)
    begin
      if (elem_ofs[2])
      begin
        rd_mux[TW-1:0] = elem_delay_q[elem_idx[IW-1:0]];
      end
      else
      begin
        rd_mux = elem_ctrl_q[elem_idx[IW-1:0]];
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= 32'h0000_0000;
    end
    else if (rd_i)
    begin
      rd_data_o <= rd_mux;
    end
    else
    begin
      rd_data_o <= 32'h0000_0000;
    end
  end
endmodule // prm_master

// ===== rtl/prm_regs.vh
`ifndef PRM_REGS_VH
`define PRM_REGS_VH

// Byte offsets
`define PRM_GLOBAL_CTRL 8'h00
`define PRM_STATUS 8'h04
`define PRM_ELEM_STATUS 8'h08
`define PRM_TRIP_STATUS 8'h0C
`define PRM_ELEM_BASE 8'h10
`define PRM_ELEM_STRIDE 8'h08
`define PRM_ELEM_DELAY_OFS 8'h04

// Global control fields
`define PRM_G_ENABLE 0
`define PRM_G_BLK_PERMIT 1
`define PRM_G_TC_HARD 2
`define PRM_G_TC_PERMIT 3
`define PRM_G_SEL_A_LSB 8
`define PRM_G_SEL_B_LSB 16
`define PRM_G_SEL_TC_LSB 24

// Element control fields
`define PRM_E_ENABLE 0
`define PRM_E_SUPERV 1
`define PRM_E_BLK_PERMIT 2
`define PRM_E_TC_HARD 3
`define PRM_E_TC_PERMIT 4
`define PRM_E_SINGLE_PH 5
`define PRM_E_REV_IL 6
`define PRM_E_SEL_BLK_LSB 8
`define PRM_E_SEL_TC_LSB 16

// Status fields
`define PRM_S_GEN_ALARM 0
`define PRM_S_GEN_TRIP 1
`define PRM_S_PH_ALARM_LSB 2
`define PRM_S_PH_TRIP_LSB 5
`define PRM_S_PROT_BLK 8
`define PRM_S_TC_BLK 9
`define PRM_S_TRIP_LSB 16

// Reset values
`define PRM_GLOBAL_RST 32'h0000_0001
`define PRM_ELEM_RST 32'h0000_0000
`define PRM_DELAY_RST 16'h0064

`endif

// ===== rtl/prm_sel.v
`timescale 1ns/100ps
// Picks one signal from the pool; index 0 means nothing assigned
module prm_sel #(
  parameter PW = 16,
  parameter SW = 5
) (
  input wire [PW-1:0] pool_i,
  input wire [SW-1:0] idx_i,
  output reg hit_o
);
  integer k;

  always @*
  begin
    hit_o = 1'b0;
    for (k = 0; k < PW; k = k + 1)
    begin
      if (idx_i == k[SW-1:0] + 1'b1)
      begin
        hit_o = pool_i[k];
      end
    end
  end
endmodule // prm_sel

// ===== rtl/prm_elem.v
`timescale 1ns/100ps
module prm_elem #(
  parameter TW = 16
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire active_i,
  input wire fault_i,
  input wire [2:0] fault_ph_i,
  input wire [TW-1:0] delay_i,
  output reg alarm_o,
  output reg trip_o,
  output reg [2:0] alarm_ph_o,
  output reg [2:0] trip_ph_o
);
  reg [TW-1:0] timer_q;
  wire elapsed;

  assign elapsed = (timer_q >= delay_i);

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      timer_q <= {TW{1'b0}};
      alarm_o <= 1'b0;
      trip_o <= 1'b0;
      alarm_ph_o <= 3'h0;
      trip_ph_o <= 3'h0;
    end
    // R19 clear on block
    else if (!active_i || !fault_i)
    begin
      timer_q <= {TW{1'b0}};
      alarm_o <= 1'b0;
      trip_o <= 1'b0;
      alarm_ph_o <= 3'h0;
      trip_ph_o <= 3'h0;
    end
    else
    begin
      // R6 alarm on fault
      alarm_o <= 1'b1;
      alarm_ph_o <= fault_ph_i;
      // R7 trip after delay
      if (elapsed)
      begin
        trip_o <= 1'b1;
        trip_ph_o <= fault_ph_i;
      end
      else
      begin
        timer_q <= timer_q + 1'b1;
      end
    end
  end
endmodule // prm_elem

// ===== testbench/prm_master_properties.sv
`timescale 1ns/100ps
module prm_master_chk #(
  parameter N = 4
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [N-1:0] fault_i,
  input wire [N-1:0] elem_alarm_o,
  input wire [N-1:0] elem_trip_o,
  input wire gen_alarm_o,
  input wire gen_trip_o,
  input wire [2:0] general_phase_alarm_o,
  input wire [2:0] general_phase_trip_o,
  input wire [N-1:0] trip_command_o,
  input wire prot_blocked_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_alarm_cause;
    (elem_alarm_o & ~$past(fault_i)) == '0;
  endproperty
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm without fault");
  property p_trip_alarm;
    (elem_trip_o & ~elem_alarm_o) == '0;
  endproperty
  a_trip_alarm: assert property (p_trip_alarm)
    else $error("trip without alarm");
  property p_gen_alarm;
    gen_alarm_o |-> $past(elem_alarm_o) != '0;
  endproperty
  a_gen_alarm: assert property (p_gen_alarm)
    else $error("general alarm without cause");
  property p_gen_trip;
    gen_trip_o |-> $past(elem_trip_o) != '0;
  endproperty
  a_gen_trip: assert property (p_gen_trip)
    else $error("general trip without cause");
  property p_cmd;
    (trip_command_o & ~$past(elem_trip_o)) == '0;
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command without trip");
  property p_ph_alarm;
    general_phase_alarm_o != 3'h0 |-> gen_alarm_o;
  endproperty
  a_ph_alarm: assert property (p_ph_alarm)
    else $error("phase alarm without general alarm");
  property p_ph_trip;
    general_phase_trip_o != 3'h0 |-> gen_trip_o;
  endproperty
  a_ph_trip: assert property (p_ph_trip)
    else $error("phase trip without general trip");
  property p_blocked;
    prot_blocked_o ##1 prot_blocked_o |->
      (elem_alarm_o | trip_command_o) == '0 && !gen_alarm_o && !gen_trip_o;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("activity while blocked");
  c_trip: cover property (gen_trip_o);
  c_cmd: cover property (trip_command_o != '0);
  c_unblock: cover property ($fell(prot_blocked_o));
endmodule // prm_master_chk
bind prm_master prm_master_chk #(.N(N)) chk_u (.*);

// ===== testbench/prm_trip_mgr_model.sv
`timescale 1ns/100ps
module prm_trip_mgr_model #(
  parameter N = 4
) (
  input wire [N-1:0] trip_command_i,
  input wire [N-1:0] assign_i,
  output wire breaker_open_o
);
  assign breaker_open_o = |(trip_command_i & assign_i);
endmodule // prm_trip_mgr_model

// ===== testbench/prm_master_tb_top.sv
`timescale 1ns/100ps
module prm_master_tb_top;
  typedef struct packed {
    logic [31:0] g;
    logic [31:0] e;
    logic [7:0] x;
    logic [11:0] r;
  } prm_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [3:0] flt = 4'h0;
  logic [11:0] ph = 12'h005;
  logic [3:0] rev = 4'h0;
  logic [7:0] ext = 8'h00;
  wire [31:0] rdat;
  wire [3:0] ea, et, tc;
  wire ga, gt, pb, brk;
  wire [2:0] pa, pt;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  prm_row_t rows [15] = '{
    '{32'h0000_0001, 32'h0000_0021, 8'h00, 12'h7ED},
    '{32'h0000_0001, 32'h0000_0001, 8'h00, 12'h7C0},
    '{32'h0000_0000, 32'h0000_0021, 8'h00, 12'h800},
    '{32'h0000_0103, 32'h0000_0021, 8'h01, 12'h800},
    '{32'h0001_0003, 32'h0000_0021, 8'h01, 12'h800},
    '{32'h0000_0103, 32'h0000_0021, 8'h00, 12'h7ED},
    '{32'h0000_0005, 32'h0000_0021, 8'h00, 12'h7AD},
    '{32'h0300_0009, 32'h0000_0021, 8'h04, 12'h7AD},
    '{32'h0000_0001, 32'h0000_0023, 8'h00, 12'h600},
    '{32'h0000_0001, 32'h0000_0020, 8'h00, 12'h000},
    '{32'h0000_0001, 32'h0000_0225, 8'h02, 12'h000},
    '{32'h0000_0001, 32'h0000_0029, 8'h00, 12'h7AD},
    '{32'h0000_0001, 32'h0001_0031, 8'h01, 12'h7AD},
    '{32'h0000_0001, 32'h0000_0061, 8'h80, 12'h000},
    '{32'h0000_0001, 32'h0000_0A25, 8'h40, 12'h000}};
  always #5 clk = ~clk;
  prm_master dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
    .wr_data_i(wdat), .wr_i(wr_s), .rd_i(rd_s), .rd_data_o(rdat),
    .fault_i(flt), .fault_ph_i(ph), .rev_interlock_i(rev),
    .ext_sig_i(ext), .elem_alarm_o(ea), .elem_trip_o(et),
    .gen_alarm_o(ga), .gen_trip_o(gt), .general_phase_alarm_o(pa),
    .general_phase_trip_o(pt), .trip_command_o(tc), .prot_blocked_o(pb));
  prm_trip_mgr_model mgr_u (.trip_command_i(tc), .assign_i(4'h1),
    .breaker_open_o(brk));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      tests_run++;
      if (got !== exp)
      begin
        n_fail++;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tick(input int n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    begin
      addr <= a;
      wdat <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    begin
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(rdat, exp);
      @(posedge clk);
    end
  endtask
  task run(input prm_row_t w);
    begin
      wr(8'h00, w.g);
      wr(8'h10, w.e);
      ext <= w.x;
      rev <= {4{w.x[7]}};
      flt <= {2'b00, w.x[6], 1'b1};
      tick(10);
      chk(32'({pb, ea[0], et[0], ga, gt, tc[0], pa, pt}), 32'(w.r));
      chk(32'(brk), 32'(w.r[6]));
      @(posedge clk);
      flt <= 4'h0;
      ext <= 8'h00;
      rev <= 4'h0;
      tick(4);
      chk(32'({ea[0], et[0]}), 32'h0000_0000);
      @(posedge clk);
    end
  endtask
  task finish_test;
    begin
      $display("Counts: %0d compared, %0d failed", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      finish_test;
    end
  end
  initial
  begin
    tick(5);
    chk(32'(pb), 32'h0000_0001);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h00, 32'h0000_0001);
    rd(8'h10, 32'h0000_0000);
    rd(8'h14, 32'h0000_0064);
    rd(8'hFC, 32'h0000_0000);
    wr(8'h14, 32'h0000_0002);
    wr(8'h18, 32'h0000_0003);
    rd(8'h14, 32'h0000_0002);
    foreach (rows[i]) run(rows[i]);
    wr(8'h00, 32'h0000_0001);
    wr(8'h10, 32'h0000_0021);
    flt <= 4'h1;
    tick(2);
    chk(32'(et[0]), 32'h0000_0000);
    tick(1);
    chk(32'(et[0]), 32'h0000_0001);
    @(posedge clk);
    rd(8'h08, 32'h0001_0001);
    rd(8'h0C, 32'h0000_0001);
    rd(8'h04, 32'h0000_00B7);
    flt <= 4'h0;
    tick(3);
    @(posedge clk);
    flt <= 4'h1;
    tick(1);
    chk(32'(et[0]), 32'h0000_0000);
    @(posedge clk);
    flt <= 4'h0;
    tick(2);
    chk(32'({ea[0], et[0]}), 32'h0000_0000);
    @(posedge clk);
    rst_n <= 1'b0;
    tick(2);
    chk(32'({pb, ga, ea}), 32'h0000_0020);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h10, 32'h0000_0000);
    rd(8'h14, 32'h0000_0064);
    finish_test;
  end
endmodule // prm_master_tb_top
